// ===== bench/epa_arbiter_assertions.sv
// concurrent checks on the exception priority arbiter ports
`timescale 1ns/10ps
`default_nettype none
`include "epa_defines.svh"
module epa_arbiter_assertions (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [`EPA_NIRQ-1:0] irq_in,
  input wire logic nmi_set_sw_in,
  input wire epa_pkg::epa_core_t core_out,
  input wire logic [`EPA_NIRQ-1:0] irq_en_out,
  input wire logic [`EPA_NPOS-1:0] pend_out,
  input wire logic [`EPA_NPOS-1:0] active_out
);
  import epa_pkg::*;
  // short alias of the core orders
  wire epa_core_t co = core_out;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // ****************
  // entry, return and chaining
  // ****************
  push_len_a: assert property ($rose(co.stack_push) |->
    co.stack_push [*8] ##1 !co.stack_push) else $error("stacking not eight cycles");
  fetch_push_a: assert property ($rose(co.stack_push) |->
    co.vec_fetch && co.take) else $error("vector fetch not alongside stacking");
  pop_len_a: assert property ($rose(co.stack_pop) |->
    co.stack_pop [*8] ##1 !co.stack_pop) else $error("unstacking not eight cycles");
  chain_len_a: assert property ($rose(co.tail_chain) |->
    co.take && !co.stack_pop ##0 co.tail_chain [*3] ##1 !co.tail_chain)
    else $error("tail chain malformed");
  mode_push_a: assert property ($fell(co.stack_push) |-> co.handler_mode)
    else $error("handler mode missing after stacking");
  take_act_a: assert property (co.take |-> active_out[co.exc_num])
    else $error("taken exception not active");
  // ****************
  // pending and enables
  // ****************
  resv_pend_a: assert property (pend_out[10:7] == 4'h0 && !pend_out[13] &&
    (pend_out[63:16] & ~`EPA_IRQ_IMPL) == 48'h0) else $error("reserved position pending");
  en_impl_a: assert property ((irq_en_out & ~`EPA_IRQ_IMPL) == 48'h0)
    else $error("unwired interrupt enabled");
  irq_pend_a: assert property (irq_in[0] && irq_en_out[0] && !active_out[16] |=>
    pend_out[16] || active_out[16]) else $error("request bit 0 not at position 16");
  nmi_src_a: assert property ($rose(pend_out[2]) |-> $past(nmi_set_sw_in))
    else $error("nmi pended without software");
  nmi_first_a: assert property (co.take && $past(pend_out[2]) &&
    !$past(active_out[2]) |-> co.exc_num == `EPA_POS_NMI) else $error("nmi not taken first");
  push_c: cover property ($rose(co.stack_push));
  chain_c: cover property ($rose(co.tail_chain));
  pop_c: cover property ($rose(co.stack_pop));
endmodule
bind epa_arbiter epa_arbiter_assertions epa_arbiter_assertions_i (.ref_clk_in(ref_clk_in),
  .reset_in(reset_in), .irq_in(irq_in), .nmi_set_sw_in(nmi_set_sw_in), .core_out(core_out),
  .irq_en_out(irq_en_out), .pend_out(pend_out), .active_out(active_out));
`default_nettype wire

// ===== bench/epa_far_model.sv
// far-side model: peripheral request levels and handler returns of the core
`timescale 1ns/10ps
`default_nettype none
`include "epa_defines.svh"
module epa_far_model (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [`EPA_NIRQ-1:0] raise_in,
  input wire logic ret_req_in,
  input wire epa_pkg::epa_core_t core_in,
  output logic [`EPA_NIRQ-1:0] irq_out,
  output logic handler_return_out
);
  import epa_pkg::*;
  logic [`EPA_NIRQ-1:0] lvl_r; // request levels held by the peripherals
  logic wait_r; // a handler end is owed
  wire logic hit_on = core_in.take && core_in.exc_num >= `EPA_POS_IRQ0;
  wire logic [`EPA_NIRQ-1:0] hit = hit_on ? 48'h1 << (core_in.exc_num - `EPA_POS_IRQ0) : '0;
  wire logic idle = core_in.handler_mode && !core_in.stack_push && !core_in.stack_pop &&
    !core_in.tail_chain;
  wire logic fire = wait_r && idle && !handler_return_out;
  // handler code clears its cause as it is entered
  assign irq_out = lvl_r & ~hit;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      lvl_r <= '0;
    end else begin
      lvl_r <= (lvl_r | raise_in) & ~hit;
    end
  end
  // one return per handler, only once stacking or chaining is over
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wait_r <= 1'b0;
      handler_return_out <= 1'b0;
    end else begin
      handler_return_out <= fire;
      wait_r <= (wait_r || ret_req_in) && !fire;
    end
  end
endmodule
`default_nettype wire

// ===== bench/test_epa_arbiter.sv
// self-checking bench of the exception priority arbiter
`timescale 1ns/10ps
`default_nettype none
`include "epa_defines.svh"
module test_epa_arbiter;
  import epa_pkg::*;
  logic clk, rst, nmi, psv, tick, ret, ret_req;
  logic [`EPA_NIRQ-1:0] irq, en_set, en_clr, raise, en_out;
  logic [`EPA_NPOS-1:0] pend, act;
  logic [1:0] group;
  logic [7:0] seen; // take, chain and number seen as a return begins
  epa_prio_wr_t prio_wr;
  epa_cfg_t cfg;
  epa_evt_t evt;
  epa_core_t core;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;
  int exp_pos [11] = '{4, 5, 5, 6, 11, 12, 14, 15, 2, 3, 3}; // position per source
  epa_arbiter epa_arbiter_i (.ref_clk_in(clk), .reset_in(rst), .irq_in(irq),
    .irq_en_set_in(en_set), .irq_en_clr_in(en_clr), .prio_wr_in(prio_wr), .group_in(group),
    .cfg_in(cfg), .evt_in(evt), .nmi_set_sw_in(nmi), .pendable_service_exception_set_sw_in(psv),
    .tick_expire_in(tick), .handler_return_in(ret), .core_out(core), .irq_en_out(en_out),
    .pend_out(pend), .active_out(act));
  epa_far_model epa_far_model_i (.ref_clk_in(clk), .reset_in(rst), .raise_in(raise),
    .ret_req_in(ret_req), .core_in(core), .irq_out(irq), .handler_return_out(ret));
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_take(input logic [5:0] pos);
    for (int i = 0; i < 60 && core.take !== 1'b1; i++) begin
      step();
    end
    check({core.take, core.exc_num}, {1'b1, pos});
  endtask
  // ask the core to end its handler, wait out unstacking or chaining
  task automatic ret_h;
    ret_req = 1'b1;
    step();
    ret_req = 1'b0;
    for (int i = 0; i < 40 && core.stack_pop !== 1'b1 && core.tail_chain !== 1'b1; i++) begin
      step();
    end
    seen = {core.take, core.tail_chain, core.exc_num};
    for (int i = 0; i < 40 && (core.stack_pop || core.tail_chain); i++) begin
      step();
    end
    step();
  endtask
  task automatic setp(input logic [5:0] pos, input logic [2:0] val);
    prio_wr = {1'b1, pos, val};
    step();
    prio_wr = '0;
    step();
  endtask
  // pulse one exception source, with handler enables per case
  task automatic fire(input int k);
    cfg = k == 9 ? 4'hD : k == 10 ? 4'hB : 4'hF;
    evt = k < 6 ? 6'h20 >> k : k == 9 ? 6'h04 : k == 10 ? 6'h08 : 6'h00;
    psv = k == 6;
    tick = k == 7;
    nmi = k == 8;
    step();
    evt = '0;
    {psv, tick, nmi} = 3'h0;
  endtask
  initial begin
    rst = 1'b1;
    {nmi, psv, tick, ret_req, en_set, en_clr, raise, group} = '0;
    prio_wr = '0;
    evt = '0;
    cfg = 4'hF;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    step();
    step();
    check(pend | act, 64'h0);
    check({core.handler_mode, core.exc_num}, {1'b0, `EPA_POS_BASE});
    en_set = '1;
    step();
    en_set = '0;
    en_clr = 48'h0000_0000_0004;
    step();
    en_clr = '0;
    check(en_out, `EPA_IRQ_IMPL & ~48'h0000_0000_0004);
    // three requests at equal level, one of them disabled
    raise = 48'h0000_0000_0007;
    step();
    raise = '0;
    wait_take(6'h10);
    check(pend[18], 1'b0);
    ret_h();
    check(seen, {2'b11, 6'h11});
    ret_h();
    check({seen[7:6], core.handler_mode, core.exc_num}, 9'h000);
    // grouping hides the subpriority difference
    setp(6'h10, 3'h2);
    setp(6'h11, 3'h3);
    group = 2'h1;
    raise = 48'h0000_0000_0001;
    step();
    raise = 48'h0000_0000_0002;
    wait_take(6'h10);
    raise = '0;
    repeat (30) step();
    check({pend[17], act[17:16]}, 3'b101);
    fire(8);
    wait_take(`EPA_POS_NMI);
    ret_h();
    check({core.handler_mode, core.exc_num}, {1'b1, 6'h10});
    setp(6'h11, 3'h1);
    wait_take(6'h11);
    ret_h();
    ret_h();
    check({core.handler_mode, core.exc_num, act[17:16]}, 9'h000);
    // every system source once, then the escalations
    group = 2'h0;
    for (int k = 0; k < 11; k++) begin
      fire(k);
      wait_take(exp_pos[k][5:0]);
      ret_h();
    end
    cfg = 4'hE;
    evt = 6'h01;
    step();
    evt = '0;
    step();
    check(pend[12], 1'b0);
    test_done();
  end
endmodule
`default_nettype wire

// ===== design/epa_arbiter.sv
// exception and interrupt prioritisation and entry sequencing
`timescale 1ns/10ps
`default_nettype none
`include "epa_defines.svh"
module epa_arbiter (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [`EPA_NIRQ-1:0] irq_in,
  input wire logic [`EPA_NIRQ-1:0] irq_en_set_in,
  input wire logic [`EPA_NIRQ-1:0] irq_en_clr_in,
  input wire epa_pkg::epa_prio_wr_t prio_wr_in,
  input wire logic [1:0] group_in,
  input wire epa_pkg::epa_cfg_t cfg_in,
  input wire epa_pkg::epa_evt_t evt_in,
  input wire logic nmi_set_sw_in,
  input wire logic pendable_service_exception_set_sw_in,
  input wire logic tick_expire_in,
  input wire logic handler_return_in,
  output epa_pkg::epa_core_t core_out,
  output logic [`EPA_NIRQ-1:0] irq_en_out,
  output logic [`EPA_NPOS-1:0] pend_out,
  output logic [`EPA_NPOS-1:0] active_out
);
  import epa_pkg::*;

  // ****************************************
  // configuration state
  // ****************************************
  logic [2:0] prio_r [`EPA_NPOS]; // settable priority per position
  logic [`EPA_NIRQ-1:0] en_r; // interrupt enables
  logic [2:0] pmask; // pre-emption bits of a priority

  // priority fields reset to zero, written one at a time
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < `EPA_NPOS; i++) begin
        prio_r[i] <= `EPA_PRIO_RST;
      end
    end else if (prio_wr_in.en) begin
      prio_r[prio_wr_in.pos] <= prio_wr_in.val;
    end
  end

  // enables: set wins over clear, unwired bits stay off
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      en_r <= '0;
    end else begin
      en_r <= ((en_r & ~irq_en_clr_in) | irq_en_set_in) & `EPA_IRQ_IMPL;
    end
  end

  // subpriority takes the low group_in bits
  assign pmask = 3'(`EPA_PRIO_ALL << group_in);

  // ****************************************
  // per-position priority keys
  // ****************************************
  logic [3:0] full_key [`EPA_NPOS]; // ranking key, lower wins
  logic [3:0] pre_key [`EPA_NPOS]; // pre-emption key
  logic [`EPA_NPOS-1:0] settable; // position has a settable field

  // settable zero lands after the two fixed levels
  function automatic logic [3:0] key_of(input logic [5:0] pos, input logic set,
                                        input logic [2:0] p);
    if (pos == `EPA_POS_NMI) begin
      key_of = `EPA_KEY_NMI;
    end else if (pos == `EPA_POS_HARD) begin
      key_of = `EPA_KEY_HARD;
    end else if (set) begin
      key_of = `EPA_KEY_SET + {1'b0, p};
    end else begin
      key_of = `EPA_KEY_NONE;
    end
  endfunction

  localparam logic [`EPA_NIRQ-1:0] IRQ_IMPL = `EPA_IRQ_IMPL; // wired bits, indexable
  genvar g;
  generate
    for (g = 0; g < `EPA_NPOS; g++) begin : g_key
      localparam logic [5:0] POS = 6'(g);
      // reserved positions have no field
      if (g >= `EPA_POS_IRQ0) begin : g_irq
        assign settable[g] = IRQ_IMPL[g - `EPA_POS_IRQ0];
      end else begin : g_sys
        assign settable[g] = (POS == `EPA_POS_MEM) || (POS == `EPA_POS_BUS) ||
                             (POS == `EPA_POS_USAGE) || (POS == `EPA_POS_SVC) ||
                             (POS == `EPA_POS_DBG) || (POS == `EPA_POS_PSV) ||
                             (POS == `EPA_POS_TICK);
      end
      assign full_key[g] = key_of(POS, settable[g], prio_r[g]);
      assign pre_key[g] = key_of(POS, settable[g], prio_r[g] & pmask);
    end
  endgenerate

  // ****************************************
  // sequencing registers
  // ****************************************
  epa_state_t st_r; // sequencing state
  logic [3:0] cnt_r; // cycles left in a stacking phase
  logic [5:0] cur_r; // running exception, zero is base level
  logic [5:0] tgt_r; // exception being entered
  logic [5:0] nest_r [16]; // pre-empted exceptions
  logic [3:0] sp_r; // nest depth
  logic [`EPA_NPOS-1:0] pend_r; // pending bits
  logic [`EPA_NPOS-1:0] active_r; // active bits

  // ****************************************
  // winner selection
  // ****************************************
  logic [5:0] best; // highest ranked pending position
  logic [3:0] best_key; // its ranking key
  logic [3:0] cur_pre; // pre-emption key of running level
  logic [3:0] ret_pre; // pre-emption key after a return
  logic [5:0] ret_to; // exception resumed after a return

  // strict compare in rising order keeps the lower position
  always_comb begin
    best = `EPA_POS_BASE;
    best_key = `EPA_KEY_NONE;
    for (int i = 1; i < `EPA_NPOS; i++) begin
      if (pend_r[i] && (full_key[i] < best_key)) begin
        best = 6'(i);
        best_key = full_key[i];
      end
    end
  end

  // base level is below every exception
  assign cur_pre = (cur_r == `EPA_POS_BASE) ? `EPA_KEY_NONE : pre_key[cur_r];
  assign ret_to = (sp_r == '0) ? `EPA_POS_BASE : nest_r[sp_r - `EPA_SP_ONE];
  assign ret_pre = (ret_to == `EPA_POS_BASE) ? `EPA_KEY_NONE : pre_key[ret_to];

  // ****************************************
  // sequencing decisions
  // ****************************************
  logic ret_ok; // a handler finishes
  logic chain_c; // tail-chain into next handler
  logic pop_c; // unstack to the resumed level
  logic preempt_c; // pre-empt running level
  logic take_c; // an exception is activated now

  assign ret_ok = (st_r == EPA_RUN) && handler_return_in && (cur_r != `EPA_POS_BASE);
  // only the pre-emption part may interrupt
  assign chain_c = ret_ok && (best_key != `EPA_KEY_NONE) &&
                   (pre_key[best] < ret_pre);
  assign pop_c = ret_ok && !chain_c;
  assign preempt_c = (st_r == EPA_RUN) && !ret_ok && (best_key != `EPA_KEY_NONE) &&
                     (pre_key[best] < cur_pre);
  assign take_c = chain_c || preempt_c;

  // ****************************************
  // fault routing
  // ****************************************
  logic mem_blk; // memory fault cannot activate
  logic bus_blk; // bus fault cannot activate
  logic usg_blk; // usage fault cannot activate
  logic svc_blk; // service call cannot activate
  logic escalate; // a fault goes to hard fault
  logic [`EPA_NPOS-1:0] set_c; // pend requests this cycle
  logic [`EPA_NPOS-1:0] clr_c; // pend clears this cycle

  // disabled or not above the running level
  assign mem_blk = !cfg_in.mem_en || (pre_key[`EPA_POS_MEM] >= cur_pre);
  assign bus_blk = !cfg_in.bus_en || (pre_key[`EPA_POS_BUS] >= cur_pre);
  assign usg_blk = !cfg_in.usage_en || (pre_key[`EPA_POS_USAGE] >= cur_pre);
  assign svc_blk = pre_key[`EPA_POS_SVC] >= cur_pre;
  assign escalate = (evt_in.mem_fault && mem_blk) || (evt_in.bus_precise && bus_blk) ||
                    (evt_in.usage_fault && usg_blk) || (evt_in.svc && svc_blk) ||
                    (evt_in.bus_imprecise && !cfg_in.bus_en);

  // requests that set pending bits
  always_comb begin
    clr_c = '0;
    if (take_c) begin
      clr_c[best] = 1'b1;
    end
    set_c = '0;
    set_c[`EPA_POS_NMI] = nmi_set_sw_in;
    set_c[`EPA_POS_HARD] = escalate;
    set_c[`EPA_POS_MEM] = evt_in.mem_fault && !mem_blk;
    // precise pends only if it can run, imprecise waits its turn
    set_c[`EPA_POS_BUS] = (evt_in.bus_precise && !bus_blk) ||
                          (evt_in.bus_imprecise && cfg_in.bus_en);
    set_c[`EPA_POS_USAGE] = evt_in.usage_fault && !usg_blk;
    set_c[`EPA_POS_SVC] = evt_in.svc && !svc_blk;
    set_c[`EPA_POS_DBG] = evt_in.dbg_req && cfg_in.dbg_en;
    set_c[`EPA_POS_PSV] = pendable_service_exception_set_sw_in;
    set_c[`EPA_POS_TICK] = tick_expire_in;
    // level requests, not repended while being taken or served
    set_c[`EPA_NPOS-1:`EPA_POS_IRQ0] = irq_in & en_r & ~active_r[`EPA_NPOS-1:`EPA_POS_IRQ0] &
                                       ~clr_c[`EPA_NPOS-1:`EPA_POS_IRQ0];
  end

  // ****************************************
  // pending and active bits
  // ****************************************
  // a system exception request in the clearing cycle is kept, an interrupt request is masked by clr_c
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~clr_c) | set_c;
    end
  end

  // active set on activation, cleared on return
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      active_r <= '0;
    end else begin
      if (ret_ok) begin
        active_r[cur_r] <= 1'b0;
      end
      if (take_c) begin
        active_r[best] <= 1'b1;
      end
    end
  end

  // ****************************************
  // entry and return sequencing
  // ****************************************
  logic hmode_r; // core in handler mode
  logic push_r; // stacking pushes running
  logic pop_r; // unstacking running
  logic fetch_r; // vector fetch running
  logic chain_r; // tail-chain entry running
  logic take_r; // activation pulse
  logic [5:0] vec_r; // position being fetched or served

  // state, counters and the orders to the core
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r <= EPA_BOOT_SP;
      cnt_r <= '0;
      cur_r <= `EPA_POS_BASE;
      tgt_r <= `EPA_POS_BASE;
      sp_r <= '0;
      hmode_r <= 1'b0;
      push_r <= 1'b0;
      pop_r <= 1'b0;
      fetch_r <= 1'b1;
      chain_r <= 1'b0;
      take_r <= 1'b0;
      vec_r <= `EPA_POS_TOP;
    end else begin
      take_r <= take_c;
      case (st_r)
        // stack top fetched first, then the reset vector
        EPA_BOOT_SP: begin
          vec_r <= `EPA_POS_RESET;
          st_r <= EPA_BOOT_VEC;
        end
        // reset drops to the base level
        EPA_BOOT_VEC: begin
          fetch_r <= 1'b0;
          vec_r <= `EPA_POS_BASE;
          st_r <= EPA_RUN;
        end
        EPA_RUN: begin
          if (chain_c) begin
            // next handler entered without unstack or stack
            tgt_r <= best;
            vec_r <= best;
            chain_r <= 1'b1;
            fetch_r <= 1'b1;
            cnt_r <= `EPA_CHAIN_CYC;
            st_r <= EPA_CHAIN;
          end else if (pop_c) begin
            // restore state of the resumed level
            pop_r <= 1'b1;
            cnt_r <= `EPA_UNSTK_CYC;
            st_r <= EPA_POP;
          end else if (preempt_c) begin
            // save the running level and fetch in parallel
            tgt_r <= best;
            vec_r <= best;
            push_r <= 1'b1;
            fetch_r <= 1'b1;
            cnt_r <= `EPA_STK_CYC;
            st_r <= EPA_PUSH;
          end
        end
        EPA_PUSH: begin
          cnt_r <= cnt_r - `EPA_CNT_LAST;
          if (cnt_r == `EPA_CNT_LAST) begin
            nest_r[sp_r] <= cur_r;
            sp_r <= sp_r + `EPA_SP_ONE;
            cur_r <= tgt_r;
            hmode_r <= 1'b1;
            push_r <= 1'b0;
            fetch_r <= 1'b0;
            st_r <= EPA_RUN;
          end
        end
        EPA_CHAIN: begin
          cnt_r <= cnt_r - `EPA_CNT_LAST;
          if (cnt_r == `EPA_CNT_LAST) begin
            cur_r <= tgt_r;
            hmode_r <= 1'b1;
            chain_r <= 1'b0;
            fetch_r <= 1'b0;
            st_r <= EPA_RUN;
          end
        end
        EPA_POP: begin
          cnt_r <= cnt_r - `EPA_CNT_LAST;
          if (cnt_r == `EPA_CNT_LAST) begin
            cur_r <= ret_to;
            vec_r <= ret_to;
            sp_r <= (sp_r == '0) ? sp_r : sp_r - `EPA_SP_ONE;
            hmode_r <= ret_to != `EPA_POS_BASE;
            pop_r <= 1'b0;
            st_r <= EPA_RUN;
          end
        end
        default: begin
          st_r <= EPA_RUN;
        end
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign core_out.handler_mode = hmode_r;
  assign core_out.stack_push = push_r;
  assign core_out.stack_pop = pop_r;
  assign core_out.vec_fetch = fetch_r;
  assign core_out.tail_chain = chain_r;
  assign core_out.take = take_r;
  assign core_out.exc_num = vec_r;
  assign irq_en_out = en_r;
  assign pend_out = pend_r;
  assign active_out = active_r;
endmodule
`default_nettype wire

// ===== pkg/epa_defines.svh
// constants of the exception priority arbiter
`ifndef EPA_DEFINES_SVH
`define EPA_DEFINES_SVH
`define EPA_NPOS 64
`define EPA_NIRQ 48
`define EPA_IRQ_IMPL 48'h083F_F1FF_C1FF
`define EPA_POS_TOP 6'h00
`define EPA_POS_RESET 6'h01
`define EPA_POS_NMI 6'h02
`define EPA_POS_HARD 6'h03
`define EPA_POS_MEM 6'h04
`define EPA_POS_BUS 6'h05
`define EPA_POS_USAGE 6'h06
`define EPA_POS_SVC 6'h0B
`define EPA_POS_DBG 6'h0C
`define EPA_POS_PSV 6'h0E
`define EPA_POS_TICK 6'h0F
`define EPA_POS_IRQ0 6'h10
`define EPA_POS_BASE 6'h00
`define EPA_KEY_NMI 4'h1
`define EPA_KEY_HARD 4'h2
`define EPA_KEY_SET 4'h3
`define EPA_KEY_NONE 4'hF
`define EPA_PRIO_RST 3'h0
`define EPA_PRIO_ALL 3'h7
`define EPA_STK_CYC 4'h8
`define EPA_UNSTK_CYC 4'h8
`define EPA_CHAIN_CYC 4'h3
`define EPA_CNT_LAST 4'h1
`define EPA_SP_ONE 4'h1
`endif

// ===== pkg/epa_pkg.sv
// types of the exception priority arbiter
package epa_pkg;
  // arbiter sequencing states
  typedef enum logic [2:0] {
    EPA_BOOT_SP = 3'b000,
    EPA_BOOT_VEC = 3'b001,
    EPA_RUN = 3'b010,
    EPA_PUSH = 3'b011,
    EPA_POP = 3'b100,
    EPA_CHAIN = 3'b101
  } epa_state_t;
  // synchronous event pulses from the core
  typedef struct packed {
    logic mem_fault;
    logic bus_precise;
    logic bus_imprecise;
    logic usage_fault;
    logic svc;
    logic dbg_req;
  } epa_evt_t;
  // handler enables
  typedef struct packed {
    logic mem_en;
    logic bus_en;
    logic usage_en;
    logic dbg_en;
  } epa_cfg_t;
  // priority field write
  typedef struct packed {
    logic en;
    logic [5:0] pos;
    logic [2:0] val;
  } epa_prio_wr_t;
  // orders to the processor core
  typedef struct packed {
    logic handler_mode;
    logic stack_push;
    logic stack_pop;
    logic vec_fetch;
    logic tail_chain;
    logic take;
    logic [5:0] exc_num;
  } epa_core_t;
endpackage
